// ---- hdl/swu_pkg.sv ----
// Shared constants, states and the frame check function of the single-wire serial slave
package swu_pkg;
	// Clock rate and the bit time assumed before any frame was seen
	localparam int unsigned CLK_HZ      = 250_000_000;
	localparam int unsigned DEF_BAUD    = 115200;
	localparam logic [15:0] DEF_BIT_CYC = 16'(CLK_HZ / DEF_BAUD);
	// Frame layout
	localparam logic [3:0]  SYNC_NIB     = 4'h5;
	localparam logic [7:0]  SYNC_PRELOAD = 8'ha0;
	localparam logic [7:0]  NODE_ADDRESS = 8'h00;
	localparam logic [7:0]  REPLY_ADDR   = 8'hff;
	localparam logic [7:0]  CRC_POLY     = 8'h07;
	localparam logic [2:0]  WR_LAST      = 3'h7;
	localparam logic [2:0]  RD_LAST      = 3'h3;
	localparam logic [3:0]  BIT_START    = 4'h0;
	localparam logic [3:0]  BIT_SYNC3    = 4'h4;
	localparam logic [3:0]  BIT_STOP     = 4'h9;
	// Timing in bit times, or in clock cycles where named so
	localparam logic [23:0] GAP_BITS     = 24'h00003f;
	localparam logic [23:0] IDLE_BITS    = 24'h00000c;
	localparam logic [23:0] RELEASE_BITS = 24'h000004;
	localparam logic [23:0] GLITCH_CYC   = 24'h000010;
	localparam logic [2:0]  DLY_STEP_LOG = 3'h3;
	// Write queue
	localparam int unsigned FIFO_W = 39;
	localparam int unsigned FIFO_D = 8;

	// Link engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SYNC = 3'b001,
		ST_RX   = 3'b010,
		ST_GAP  = 3'b011,
		ST_REC  = 3'b100,
		ST_DLY  = 3'b101,
		ST_TX   = 3'b110,
		ST_REL  = 3'b111
	} state_t;

	// Frame check over one byte, least significant bit first
	function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c;
		for (int i = 0; i < 8; i++) begin
			r = (r[7] ^ b[i]) ? ({r[6:0], 1'b0} ^ CRC_POLY) : {r[6:0], 1'b0};
		end
		return r;
	endfunction : crc8
endpackage : swu_pkg

// ---- hdl/single_wire_uart_slave.sv ----
// Single-wire serial slave: receiver, reply transmitter and write queue
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Write queue, storage in flip-flops, output stage registered
module swu_fifo #(
	parameter int unsigned W = 39,
	parameter int unsigned D = 8
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic         en_i,
	// Filling side
	input  wire logic         in_valid_i,
	output logic              in_ready_o,
	input  wire logic [W-1:0] in_data_i,
	// Draining side
	output logic              out_valid_o,
	input  wire logic         out_ready_i,
	output logic [W-1:0]      out_data_o
);
	localparam int unsigned AW = (D > 1) ? $clog2(D) : 1;
	localparam int unsigned CW = $clog2(D + 1);

	logic [W-1:0]  mem_q [D];
	logic [W-1:0]  mem_d [D];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [CW-1:0] n_q, n_d;
	logic          ov_q, ov_d;
	logic [W-1:0]  od_q, od_d;
	logic          push, pop;

	// Output stage refills as soon as it is free or taken
	always_comb begin
		mem_d = mem_q;
		wp_d  = wp_q;
		rp_d  = rp_q;
		ov_d  = ov_q;
		od_d  = od_q;
		push  = in_valid_i && (n_q != CW'(D));
		pop   = (n_q != '0) && (!ov_q || out_ready_i);
		if (out_ready_i) begin
			ov_d = 1'b0;
		end
		if (push) begin
			mem_d[wp_q] = in_data_i;
			wp_d        = (wp_q == AW'(D - 1)) ? '0 : wp_q + AW'(1);
		end
		if (pop) begin
			ov_d = 1'b1;
			od_d = mem_q[rp_q];
			rp_d = (rp_q == AW'(D - 1)) ? '0 : rp_q + AW'(1);
		end
		n_d = n_q + CW'(push) - CW'(pop);
	end

	// Register stage
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			wp_q <= '0;
			rp_q <= '0;
			n_q  <= '0;
			ov_q <= 1'b0;
			od_q <= '0;
		end else if (en_i) begin
			mem_q <= mem_d;
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			n_q   <= n_d;
			ov_q  <= ov_d;
			od_q  <= od_d;
		end
	end

	assign in_ready_o  = (n_q != CW'(D));
	assign out_valid_o = ov_q;
	assign out_data_o  = od_q;
endmodule : swu_fifo

////////////////////////////////////////////////////////////////////////////////
// Function
// - Every frame opens with sync nibble 1,0,1,0 then reserved zero bits.
// - Each byte has a low start bit and a high stop bit.
// - Bit time measured from start edge to the sync bit 2/3 falling edge.
// - Bit divider resynchronises to the host rate on every frame.
// - Bits go LSB first; 32-bit words go most significant byte first.
// - Write frame: sync, node, flag plus address, four data bytes, check byte.
// - Node address is fixed at zero.
// - Over 63 bit times between start bits abandons the frame.
// - Low pulse under 16 clocks is a glitch; wait 12 idle bit times.
// - Check mismatch and frame errors recover like a glitch.
// - Accepted writes bump an 8-bit wrapping counter; reads do not.
// - Read request: sync, node, cleared flag plus address, check byte.
// - Reply uses the bit time measured on the read request.
// - Reply waits a delay in steps of eight bit times, default eight.
// - Reply: sync, address 0xFF, flag plus address, four data bytes, check.
// - Line driver released four bit times after the final stop bit.
// - Check byte is CRC-8, polynomial 0x07, start zero, LSB first.
// - Only frames with good check and own node address are acted on.
module single_wire_uart_slave (
	// Clock, reset, enable
	input  wire logic        sys_clk_i,
	input  wire logic        reset_i,
	input  wire logic        clk_en_i,
	// Shared serial line
	input  wire logic        serial_io_line_i,
	output logic             serial_io_line_o,
	output logic             serial_io_line_oe_o,
	// Settings
	input  wire logic [3:0]  reply_delay_setting_i,
	// Accepted writes
	output logic             wr_valid_o,
	input  wire logic        wr_ready_i,
	output logic [6:0]       wr_addr_o,
	output logic [31:0]      wr_data_o,
	// Read requests
	output logic             rd_req_o,
	output logic [6:0]       rd_addr_o,
	input  wire logic [31:0] rd_data_i,
	// Status
	output logic [7:0]       write_count_o,
	output logic             frame_err_o
);
	swu_pkg::state_t st_q, st_d;
	logic        s1_q, s2_q, s3_q;
	logic [15:0] cnt_q, cnt_d, bit_q, bit_d, good_q, good_d;
	logic [23:0] lcnt_q, lcnt_d;
	logic [3:0]  bidx_q, bidx_d;
	logic [2:0]  byte_q, byte_d, last;
	logic        edg_q, edg_d, wr_q, wr_d, fail;
	logic [7:0]  sh_q, sh_d, crc_q, crc_d, addr_q, addr_d, reg_q, reg_d;
	logic [31:0] data_q, data_d;
	logic [63:0] txsh_q, txsh_d, frame;
	logic        line_q, line_d, oe_q, oe_d, rd_req_q, rd_req_d, err_q, err_d;
	logic        push_q, push_d, fifo_rdy;
	logic [6:0]  rd_addr_q, rd_addr_d;
	logic [7:0]  wcnt_q, wcnt_d, fcrc;
	logic [38:0] qdata_q, qdata_d;
	logic        line, fall;
	logic [15:0] half;
	logic [23:0] gap_lim, idle_lim, rel_lim, dly_lim;
	logic [6:0]  dly_bits;

	////////////////////////////////////////////////////////////////////////////
	// Line synchroniser; the third stage only feeds the edge detector
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
		end else if (clk_en_i) begin
			s1_q <= serial_io_line_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign line = s2_q;
	assign fall = s3_q & ~s2_q;
	assign half = bit_q >> 1;

	// Limits in cycles; gap uses the last good frame's bit time
	assign dly_bits = (reply_delay_setting_i == 4'h0) ? 7'h01 : {3'h0, reply_delay_setting_i};
	assign gap_lim  = 24'(good_q) * swu_pkg::GAP_BITS;
	assign idle_lim = 24'(bit_q) * swu_pkg::IDLE_BITS;
	assign rel_lim  = 24'(bit_q) * swu_pkg::RELEASE_BITS;
	assign dly_lim  = 24'(bit_q) * 24'({dly_bits, swu_pkg::DLY_STEP_LOG'(0)});
	assign last     = wr_q ? swu_pkg::WR_LAST : swu_pkg::RD_LAST;

	////////////////////////////////////////////////////////////////////////////
	// Reply frame, data high byte first, check byte computed on the fly
	always_comb begin
		frame = {8'h00, rd_data_i[7:0], rd_data_i[15:8], rd_data_i[23:16],
			rd_data_i[31:24], {1'b0, reg_q[6:0]}, swu_pkg::REPLY_ADDR,
			4'h0, swu_pkg::SYNC_NIB};
		fcrc = 8'h00;
		for (int i = 0; i < 7; i++) begin
			fcrc = swu_pkg::crc8(fcrc, frame[i*8 +: 8]);
		end
		frame[63:56] = fcrc;
	end

	////////////////////////////////////////////////////////////////////////////
	// Link engine next state
	always_comb begin
		st_d      = st_q;
		cnt_d     = cnt_q;
		lcnt_d    = lcnt_q + 24'h1;
		bit_d     = bit_q;
		good_d    = good_q;
		bidx_d    = bidx_q;
		byte_d    = byte_q;
		edg_d     = edg_q;
		sh_d      = sh_q;
		crc_d     = crc_q;
		addr_d    = addr_q;
		reg_d     = reg_q;
		data_d    = data_q;
		wr_d      = wr_q;
		txsh_d    = txsh_q;
		rd_req_d  = 1'b0;
		push_d    = 1'b0;
		wcnt_d    = wcnt_q;
		fail      = 1'b0;
		case (st_q)
			swu_pkg::ST_IDLE: begin
				if (fall) begin
					st_d   = swu_pkg::ST_SYNC;
					lcnt_d = 24'h0;
					edg_d  = 1'b0;
				end
			end
			swu_pkg::ST_SYNC: begin
				// Short low pulse is noise, not a start bit
				// Low time is the count plus one, so a 16-cycle pulse still opens a frame
				if (line && lcnt_q + 24'h1 < swu_pkg::GLITCH_CYC) begin
					fail = 1'b1;
				end else if (lcnt_q[23:18] != 6'h0) begin
					fail = 1'b1;
				end else if (fall) begin
					if (edg_q) begin
						// Count stops one short of four bit times; truncation would speed up the reply
						bit_d  = 16'((lcnt_q + 24'h1) >> 2);
						st_d   = swu_pkg::ST_RX;
						bidx_d = swu_pkg::BIT_SYNC3;
						cnt_d  = 16'h0;
						byte_d = 3'h0;
						sh_d   = swu_pkg::SYNC_PRELOAD;
						crc_d  = 8'h00;
					end else begin
						edg_d = 1'b1;
					end
				end
			end
			swu_pkg::ST_RX: begin
				cnt_d = cnt_q + 16'h1;
				if (cnt_q == half) begin
					if (bidx_q == swu_pkg::BIT_START) begin
						fail = line;
					end else if (bidx_q != swu_pkg::BIT_STOP) begin
						sh_d = {line, sh_q[7:1]};
					end else if (!line) begin
						fail = 1'b1;
					end else begin
						if (byte_q == 3'h1) begin
							addr_d = sh_q;
						end
						if (byte_q == 3'h2) begin
							reg_d = sh_q;
							wr_d  = sh_q[7];
						end
						if (byte_q > 3'h2 && byte_q != last) begin
							data_d = {data_q[23:0], sh_q};
						end
						if (byte_q > 3'h2 && byte_q == last) begin
							if (sh_q != crc_q) begin
								fail = 1'b1;
							end else if (addr_q != swu_pkg::NODE_ADDRESS) begin
								st_d = swu_pkg::ST_IDLE;
							end else if (!wr_q) begin
								good_d   = bit_q;
								rd_req_d = 1'b1;
								st_d     = swu_pkg::ST_DLY;
								lcnt_d   = 24'h0;
							end else if (fifo_rdy) begin
								good_d = bit_q;
								push_d = 1'b1;
								wcnt_d = wcnt_q + 8'h01;
								st_d   = swu_pkg::ST_IDLE;
							end else begin
								fail = 1'b1;
							end
						end else begin
							crc_d  = swu_pkg::crc8(crc_q, sh_q);
							byte_d = byte_q + 3'h1;
							st_d   = swu_pkg::ST_GAP;
						end
					end
				end
				if (cnt_q == bit_q - 16'h1) begin
					cnt_d  = 16'h0;
					bidx_d = bidx_q + 4'h1;
				end
			end
			swu_pkg::ST_GAP: begin
				if (lcnt_q >= gap_lim) begin
					fail = 1'b1;
				end else if (fall) begin
					st_d   = swu_pkg::ST_RX;
					bidx_d = swu_pkg::BIT_START;
					cnt_d  = 16'h0;
					lcnt_d = 24'h0;
				end
			end
			swu_pkg::ST_REC: begin
				// Any low level restarts the idle wait
				if (!line) begin
					lcnt_d = 24'h0;
				end else if (lcnt_q >= idle_lim) begin
					st_d = swu_pkg::ST_IDLE;
				end
			end
			swu_pkg::ST_DLY: begin
				if (lcnt_q >= dly_lim - 24'h1) begin
					st_d   = swu_pkg::ST_TX;
					txsh_d = frame;
					bidx_d = swu_pkg::BIT_START;
					byte_d = 3'h0;
					cnt_d  = 16'h0;
				end
			end
			swu_pkg::ST_TX: begin
				cnt_d = cnt_q + 16'h1;
				if (cnt_q == bit_q - 16'h1) begin
					cnt_d = 16'h0;
					if (bidx_q != swu_pkg::BIT_STOP) begin
						bidx_d = bidx_q + 4'h1;
					end else if (byte_q == swu_pkg::WR_LAST) begin
						st_d   = swu_pkg::ST_REL;
						lcnt_d = 24'h0;
					end else begin
						bidx_d = swu_pkg::BIT_START;
						byte_d = byte_q + 3'h1;
						txsh_d = {8'h00, txsh_q[63:8]};
					end
				end
			end
			swu_pkg::ST_REL: begin
				if (lcnt_q >= rel_lim - 24'h1) begin
					st_d = swu_pkg::ST_IDLE;
				end
			end
			default: begin
				st_d = swu_pkg::ST_IDLE;
			end
		endcase
		// Every error funnels into the idle recovery wait
		if (fail) begin
			st_d   = swu_pkg::ST_REC;
			lcnt_d = 24'h0;
		end
		err_d     = fail;
		rd_addr_d = rd_req_d ? reg_q[6:0] : rd_addr_q;
		qdata_d   = {reg_q[6:0], data_d};
		// Driver: start low, data LSB first, stop and release phase high
		oe_d   = (st_d == swu_pkg::ST_TX) || (st_d == swu_pkg::ST_REL);
		line_d = 1'b1;
		if (st_d == swu_pkg::ST_TX && bidx_d == swu_pkg::BIT_START) begin
			line_d = 1'b0;
		end else if (st_d == swu_pkg::ST_TX && bidx_d != swu_pkg::BIT_STOP) begin
			line_d = txsh_d[3'(bidx_d - 4'h1)];
		end
	end

	// Link engine registers
	always_ff @(posedge sys_clk_i) begin
		if (reset_i) begin
			st_q      <= swu_pkg::ST_IDLE;
			cnt_q     <= 16'h0;
			lcnt_q    <= 24'h0;
			bit_q     <= swu_pkg::DEF_BIT_CYC;
			good_q    <= swu_pkg::DEF_BIT_CYC;
			bidx_q    <= 4'h0;
			byte_q    <= 3'h0;
			edg_q     <= 1'b0;
			sh_q      <= 8'h00;
			crc_q     <= 8'h00;
			addr_q    <= 8'h00;
			reg_q     <= 8'h00;
			data_q    <= 32'h0;
			wr_q      <= 1'b0;
			txsh_q    <= 64'h0;
			line_q    <= 1'b1;
			oe_q      <= 1'b0;
			rd_req_q  <= 1'b0;
			rd_addr_q <= 7'h00;
			err_q     <= 1'b0;
			push_q    <= 1'b0;
			wcnt_q    <= 8'h00;
			qdata_q   <= 39'h0;
		end else if (clk_en_i) begin
			st_q      <= st_d;
			cnt_q     <= cnt_d;
			lcnt_q    <= lcnt_d;
			bit_q     <= bit_d;
			good_q    <= good_d;
			bidx_q    <= bidx_d;
			byte_q    <= byte_d;
			edg_q     <= edg_d;
			sh_q      <= sh_d;
			crc_q     <= crc_d;
			addr_q    <= addr_d;
			reg_q     <= reg_d;
			data_q    <= data_d;
			wr_q      <= wr_d;
			txsh_q    <= txsh_d;
			line_q    <= line_d;
			oe_q      <= oe_d;
			rd_req_q  <= rd_req_d;
			rd_addr_q <= rd_addr_d;
			err_q     <= err_d;
			push_q    <= push_d;
			wcnt_q    <= wcnt_d;
			qdata_q   <= qdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Write queue; a full queue refuses the frame, so the counter tells the host
	swu_fifo #(
		.W (swu_pkg::FIFO_W),
		.D (swu_pkg::FIFO_D)
	) u_wq (
		.clk_i       (sys_clk_i),
		.reset_i     (reset_i),
		.en_i        (clk_en_i),
		.in_valid_i  (push_q),
		.in_ready_o  (fifo_rdy),
		.in_data_i   (qdata_q),
		.out_valid_o (wr_valid_o),
		.out_ready_i (wr_ready_i),
		.out_data_o  ({wr_addr_o, wr_data_o})
	);

	assign serial_io_line_o    = line_q;
	assign serial_io_line_oe_o = oe_q;
	assign rd_req_o            = rd_req_q;
	assign rd_addr_o           = rd_addr_q;
	assign write_count_o       = wcnt_q;
	assign frame_err_o         = err_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks; they assume clk_en_i held high
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (reset_i);

	sequence s_tx_start;
		$rose(st_q == swu_pkg::ST_TX);
	endsequence
	sequence s_sync_edge;
		st_q == swu_pkg::ST_SYNC && fall && edg_q && lcnt_q[23:18] == 6'h0 && !line;
	endsequence

	chk_start_low: assert property (st_q == swu_pkg::ST_TX && bidx_q == 4'h0 |-> !line_q && oe_q)
		else $error("start bit not driven low");
	chk_reply_head: assert property (s_tx_start |-> txsh_q[15:0] == 16'hff05)
		else $error("reply header wrong");
	chk_bit_measure: assert property (s_sync_edge
		|=> bit_q == 16'(($past(lcnt_q) + 24'h1) >> 2))
		else $error("bit time not taken from sync edge");
	chk_glitch_rec: assert property (st_q == swu_pkg::ST_SYNC && line && lcnt_q < 24'h00000f
		|=> st_q == swu_pkg::ST_REC && $past(err_d))
		else $error("glitch not rejected");
	chk_gap_abort: assert property (st_q == swu_pkg::ST_GAP && lcnt_q >= gap_lim
		|=> st_q == swu_pkg::ST_REC)
		else $error("gap timeout missed");
	chk_count_step: assert property (wcnt_q != $past(wcnt_q) |-> push_q && wcnt_q == $past(wcnt_q) + 8'h01)
		else $error("write counter moved without a write");
	chk_read_delay: assert property (rd_req_q |-> st_q == swu_pkg::ST_DLY ##1 st_q == swu_pkg::ST_DLY)
		else $error("reply not delayed");
	chk_release_oe: assert property (st_q == swu_pkg::ST_REL && lcnt_q >= rel_lim - 24'h1
		|=> !oe_q && line_q)
		else $error("driver not released");
	chk_stop_high: assert property (st_q == swu_pkg::ST_TX && bidx_q == 4'h9 |-> line_q [*1] ##0 oe_q)
		else $error("stop bit not high");
endmodule : single_wire_uart_slave

// ---- testbench/host_uart_model.sv ----
// Host side of the shared serial line: frame sender, glitch maker and reply catcher
`timescale 1ns/1ps

module host_uart_model (
	// Clock
	input  wire logic sys_clk_i,
	// Shared line, resolved level in and own drive out
	input  wire logic line_i,
	output logic      line_drv_o
);
	logic [7:0] rx [8];
	int         bt;

	// Line idles high; the bench sets the bit time per scenario
	initial begin
		line_drv_o = 1'b1;
		bt = 32;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Frame check, an independent copy from the design's
	function automatic logic [7:0] crc_next(input logic [7:0] c, input logic [7:0] b);
		for (int i = 0; i < 8; i++) begin
			c = (c[7] != b[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
		end
		return c;
	endfunction : crc_next

	// One bit held a full bit time, changed just after the edge
	task automatic put_bit(input logic v);
		line_drv_o = v;
		repeat (bt) @(posedge sys_clk_i);
		#1;
	endtask : put_bit

	// Sends n bytes from the top of f; the last byte becomes the check, xor flip
	task automatic send_frame(input logic [63:0] f, input int n, input logic [7:0] flip);
		logic [7:0] c;
		logic [7:0] b;
		c = 8'h00;
		@(posedge sys_clk_i);
		#1;
		for (int k = 0; k < n; k++) begin
			b = (k == n - 1) ? (c ^ flip) : f[63 - 8 * k -: 8];
			c = crc_next(c, b);
			put_bit(1'b0);
			for (int i = 0; i < 8; i++) begin
				put_bit(b[i]);
			end
			put_bit(1'b1);
		end
	endtask : send_frame

	// Short low pulse on an idle line
	task automatic pulse_low(input int n);
		@(posedge sys_clk_i);
		#1;
		line_drv_o = 1'b0;
		repeat (n) @(posedge sys_clk_i);
		#1;
		line_drv_o = 1'b1;
	endtask : pulse_low

	// Catches eight reply bytes, sampling mid-bit; ok drops on a missing start
	task automatic recv_frame(output logic ok);
		int w;
		ok = 1'b1;
		for (int k = 0; k < 8; k++) begin
			w = 0;
			// Looked at a step after the edge, once the design's flops have settled
			while (line_i !== 1'b0 && w < 40 * bt) begin
				@(posedge sys_clk_i);
				#1;
				w++;
			end
			if (w >= 40 * bt) begin
				ok = 1'b0;
			end
			repeat (bt / 2) @(posedge sys_clk_i);
			for (int i = 0; i < 8; i++) begin
				repeat (bt) @(posedge sys_clk_i);
				#1;
				rx[k][i] = line_i;
			end
			// Stop bit middle; the next start is polled from here
			repeat (bt) @(posedge sys_clk_i);
			#1;
		end
	endtask : recv_frame
endmodule : host_uart_model

// ---- testbench/tb.sv ----
// Self-checking bench of the single-wire serial slave
`timescale 1ns/1ps

module tb;
	logic        sys_clk_i;
	logic        reset_i;
	logic        wr_ready_i;
	logic [3:0]  reply_delay_setting_i;
	logic [31:0] rd_data_i;
	logic        serial_io_line_o;
	logic        serial_io_line_oe_o;
	logic        wr_valid_o;
	logic [6:0]  wr_addr_o;
	logic [31:0] wr_data_o;
	logic        rd_req_o;
	logic [6:0]  rd_addr_o;
	logic [7:0]  write_count_o;
	logic        frame_err_o;
	logic        host_drv;
	logic        line_w;
	logic        oe_last;
	int          mismatches;
	int          num_checks;
	int          cyc;
	int          errs;
	int          rds;
	int          req_cyc;
	int          rise_cyc;
	int          fall_cyc;

	// Released line is pulled high; either party can pull it low
	assign line_w = (serial_io_line_oe_o ? serial_io_line_o : 1'b1) & host_drv;

	single_wire_uart_slave single_wire_uart_slave_i (
		.sys_clk_i(sys_clk_i), .reset_i(reset_i), .clk_en_i(1'b1),
		.serial_io_line_i(line_w), .serial_io_line_o(serial_io_line_o),
		.serial_io_line_oe_o(serial_io_line_oe_o),
		.reply_delay_setting_i(reply_delay_setting_i),
		.wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_addr_o(wr_addr_o),
		.wr_data_o(wr_data_o), .rd_req_o(rd_req_o), .rd_addr_o(rd_addr_o),
		.rd_data_i(rd_data_i), .write_count_o(write_count_o), .frame_err_o(frame_err_o)
	);

	host_uart_model host_uart_model_i (
		.sys_clk_i(sys_clk_i), .line_i(line_w), .line_drv_o(host_drv)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Event monitor: pulses are counted, driver edges stamped in cycles
	always @(posedge sys_clk_i) begin
		cyc <= cyc + 1;
		oe_last <= serial_io_line_oe_o;
		if (frame_err_o === 1'b1)
			errs <= errs + 1;
		if (rd_req_o === 1'b1) begin
			rds <= rds + 1;
			req_cyc <= cyc;
		end
		if (serial_io_line_oe_o === 1'b1 && oe_last !== 1'b1)
			rise_cyc <= cyc;
		if (serial_io_line_oe_o !== 1'b1 && oe_last === 1'b1)
			fall_cyc <= cyc;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : wrap_up

	// Idle line for n bit times of the current host rate
	task automatic idle(input int n);
		repeat (n * host_uart_model_i.bt) @(posedge sys_clk_i);
		#1;
	endtask : idle

	function automatic logic [63:0] wr_frame(input logic [7:0] node, input logic [6:0] a,
		input logic [31:0] d);
		return {8'h05, node, 1'b1, a, d, 8'h00};
	endfunction : wr_frame

	// Takes one queued write, bounded wait for valid
	task automatic pop(input logic [6:0] a, input logic [31:0] d);
		int w;
		w = 0;
		while (wr_valid_o !== 1'b1 && w < 100) begin
			@(posedge sys_clk_i);
			#1;
			w++;
		end
		if (w >= 100) begin
			mismatches++;
			wrap_up();
		end
		chk("wr_addr", 32'(a), 32'(wr_addr_o));
		chk("wr_data", d, wr_data_o);
		wr_ready_i = 1'b1;
		@(posedge sys_clk_i);
		#1;
		wr_ready_i = 1'b0;
		@(posedge sys_clk_i);
		#1;
	endtask : pop

	////////////////////////////////////////////////////////////////////////////////
	// Nine writes fill queue and output stage, the tenth is refused
	task automatic test_fill;
		int e0;
		e0 = errs;
		for (int k = 0; k < 10; k++) begin
			host_uart_model_i.send_frame(wr_frame(8'h00, 7'(k + 3),
				{4{8'(k)}} ^ 32'h5a3c9600), 8, 8'h00);
			idle(14);
		end
		chk("write_count", 32'h9, 32'(write_count_o));
		chk("frame_err", 32'(e0 + 1), 32'(errs));
		for (int k = 0; k < 9; k++) begin
			pop(7'(k + 3), {4{8'(k)}} ^ 32'h5a3c9600);
		end
		$display("test fill done");
	endtask : test_fill

	// Read at a new rate, longer reply delay, reply bytes and release timing
	task automatic test_read;
		logic       ok;
		logic [7:0] c;
		logic [7:0] exp [8];
		int         r0;
		host_uart_model_i.bt = 48;
		reply_delay_setting_i = 4'h2;
		rd_data_i = 32'hc0ffee11;
		r0 = rds;
		host_uart_model_i.send_frame({8'h05, 8'h00, 8'h2a, 8'h00, 32'h0}, 4, 8'h00);
		host_uart_model_i.recv_frame(ok);
		idle(6);
		exp = '{8'h05, 8'hff, 8'h2a, 8'hc0, 8'hff, 8'hee, 8'h11, 8'h00};
		c = 8'h00;
		for (int k = 0; k < 7; k++) begin
			c = host_uart_model_i.crc_next(c, exp[k]);
		end
		exp[7] = c;
		chk("reply_seen", 32'h1, 32'(ok));
		// A missing reply leaves nothing worth comparing
		if (ok !== 1'b1) begin
			wrap_up();
		end
		chk("rd_req", 32'(r0 + 1), 32'(rds));
		chk("rd_addr", 32'h2a, 32'(rd_addr_o));
		for (int k = 0; k < 8; k++) begin
			chk("reply_byte", 32'(exp[k]), 32'(host_uart_model_i.rx[k]));
		end
		chk("reply_delay", 32'h1, 32'((rise_cyc - req_cyc) inside {[765:771]}));
		chk("release", 32'h1, 32'((fall_cyc - rise_cyc) inside {[4029:4035]}));
		chk("write_count", 32'h9, 32'(write_count_o));
		$display("test read done");
	endtask : test_read

	// Bad check byte is dropped, a good frame after recovery is taken
	task automatic test_bad_crc;
		int e0;
		e0 = errs;
		// Rate rises here, never an abrupt drop that the gap timeout would reject
		host_uart_model_i.bt = 32;
		host_uart_model_i.send_frame(wr_frame(8'h00, 7'h11, 32'h12345678), 8, 8'h01);
		idle(14);
		chk("frame_err", 32'(e0 + 1), 32'(errs));
		chk("write_count", 32'h9, 32'(write_count_o));
		host_uart_model_i.send_frame(wr_frame(8'h00, 7'h11, 32'h12345678), 8, 8'h00);
		idle(2);
		chk("write_count", 32'ha, 32'(write_count_o));
		pop(7'h11, 32'h12345678);
		$display("test bad_crc done");
	endtask : test_bad_crc

	// Foreign node address is ignored without an error
	task automatic test_node;
		int e0;
		e0 = errs;
		host_uart_model_i.send_frame(wr_frame(8'h01, 7'h33, 32'h0badf00d), 8, 8'h00);
		idle(4);
		chk("write_count", 32'ha, 32'(write_count_o));
		chk("wr_valid", 32'h0, 32'(wr_valid_o));
		chk("frame_err", 32'(e0), 32'(errs));
		$display("test node done");
	endtask : test_node

	// Pause over 63 bit times between bytes abandons the frame
	task automatic test_gap;
		int e0;
		e0 = errs;
		host_uart_model_i.send_frame(wr_frame(8'h00, 7'h44, 32'h0), 2, 8'h00);
		idle(70);
		chk("frame_err", 32'(e0 + 1), 32'(errs));
		chk("write_count", 32'ha, 32'(write_count_o));
		$display("test gap done");
	endtask : test_gap

	// Short pulse counts as a glitch, then reception resumes after recovery
	task automatic test_glitch;
		int e0;
		idle(14);
		e0 = errs;
		host_uart_model_i.pulse_low(8);
		idle(14);
		chk("frame_err", 32'(e0 + 1), 32'(errs));
		host_uart_model_i.send_frame(wr_frame(8'h00, 7'h7f, 32'hffff0001), 8, 8'h00);
		idle(2);
		chk("write_count", 32'hb, 32'(write_count_o));
		pop(7'h7f, 32'hffff0001);
		$display("test glitch done");
	endtask : test_glitch

	////////////////////////////////////////////////////////////////////////////////
	// Clock, 4 ns period
	initial begin
		sys_clk_i = 1'b0;
		forever #2 sys_clk_i = ~sys_clk_i;
	end

	// Main sequence
	initial begin
		reset_i = 1'b1;
		wr_ready_i = 1'b0;
		reply_delay_setting_i = 4'h0;
		rd_data_i = 32'h0;
		mismatches = 0;
		num_checks = 0;
		cyc = 0;
		errs = 0;
		rds = 0;
		req_cyc = 0;
		rise_cyc = 0;
		fall_cyc = 0;
		oe_last = 1'b0;
		repeat (10) @(posedge sys_clk_i);
		#1;
		reset_i = 1'b0;
		chk("reset_oe", 32'h0, 32'(serial_io_line_oe_o));
		chk("reset_count", 32'h0, 32'(write_count_o));
		idle(4);
		test_fill();
		test_read();
		test_bad_crc();
		test_node();
		test_gap();
		test_glitch();
		wrap_up();
	end
endmodule : tb
